// *** testbench/ctrl_port.sv ***
// Purpose: controller timer port model on the far side of the output wire
// Assumes: line is the resolved wire level, sampled on mclk
// Notes:   pull_cyc of 0 means no request; dropping go abandons a measurement
`timescale 1ns/1ps
`default_nettype none
module ctrl_port (
  input  wire logic       mclk,
  input  wire logic       go,
  input  wire logic [3:0] pull_cyc,
  input  wire logic       line,
  output var  logic       pull,
  output var  logic [7:0] th,
  output var  logic [7:0] tl,
  output var  logic       done
);
  initial begin
    pull = 1'b0;
    done = 1'b0;
  end
  always begin
    // go is taken on the rising edge so a new run cannot race the bench lowering it
    @(posedge mclk iff go);
    done = 1'b0;
    th = 8'h00;
    tl = 8'h00;
    if (pull_cyc != 4'h0) begin
      @(negedge mclk);
      pull = 1'b1;
      repeat (pull_cyc) @(negedge mclk);
      pull = 1'b0;
      @(posedge mclk);
    end else begin
      while (line && go) @(posedge mclk);
      while (!line && go) @(posedge mclk);
    end
    // both phases on one clock, so the ratio needs no known frequency
    while (line && go) begin
      th++;
      @(posedge mclk);
    end
    while (!line && go) begin
      tl++;
      @(posedge mclk);
    end
    done = go;
  end
endmodule : ctrl_port
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the pwm temperature output
// Assumes: TICK_CYCLES 2, TH_NOM_TICKS 8, push-pull, pull-up on the wire
// Notes:   straps latch once, so every setting needs its own power-up
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  comparisons++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
  end \
end
module tb_top;
  typedef struct packed {
    logic [1:0]  m;
    logic [1:0]  r;
    logic [15:0] t;
    logic [3:0]  p;
    logic [7:0]  eh;
    logic [7:0]  el;
  } row_t;
  logic                     mclk = 1'b0;
  logic                     rst = 1'b1;
  pwm_temp_pkg::pin_sense_t mode = '0;
  pwm_temp_pkg::pin_sense_t rate = '0;
  logic [15:0]              tlt = 16'h0005;
  logic                     line;
  logic                     go = 1'b0;
  logic [3:0]               pc = 4'h0;
  logic                     pull;
  logic [7:0]               th;
  logic [7:0]               tl;
  logic                     done;
  pwm_temp_pkg::pin_drive_t op;
  int                       error_cnt = 0;
  int                       comparisons = 0;
  int                       i;
  int                       k;
  int                       lows;
  // one-shot highs read one cycle longer: the wire is already high at release
  row_t rows [7] = '{'{2'h0, 2'h0, 16'h0005, 4'h0, 8'h10, 8'h0a}, '{2'h0, 2'h1, 16'h000c, 4'h0, 8'h04, 8'h06},
                     '{2'h0, 2'h2, 16'h0014, 4'h0, 8'h20, 8'h0a}, '{2'h0, 2'h2, 16'h0003, 4'h0, 8'h20, 8'h02},
                     '{2'h1, 2'h0, 16'h0007, 4'h4, 8'h11, 8'h0e}, '{2'h1, 2'h1, 16'h0008, 4'h4, 8'h05, 8'h04},
                     '{2'h1, 2'h2, 16'h0009, 4'h4, 8'h21, 8'h04}};
  always #2.5 mclk = ~mclk;
  assign line = pull ? 1'b0 : (op.oe ? op.level : 1'b1);
  pwm_temp_out #(.TICK_CYCLES(2), .TH_NOM_TICKS(8), .OPEN_DRAIN(1'b0)) u_pwm_temp_out (.mclk(mclk), .rst(rst),
    .mode_select_pin(mode), .rate_or_chain_input(rate), .temp_low_ticks(tlt), .out_in(line), .out_pin(op));
  ctrl_port u_ctrl_port (.mclk(mclk), .go(go), .pull_cyc(pc), .line(line), .pull(pull), .th(th), .tl(tl),
    .done(done));
  task automatic test_done();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task automatic pwr_up(input logic [1:0] m, input logic [1:0] r);
    mode = m;
    rate = r;
    rst = 1'b1;
    repeat (20) @(negedge mclk);
    `CHK("out_pin in reset", 3'h0, op)
    rst = 1'b0;
    repeat (3) @(negedge mclk);
  endtask : pwr_up
  task automatic measure(input logic [3:0] p);
    pc = p;
    go = 1'b1;
    repeat (2) @(negedge mclk);
    for (k = 0; k < 400 && done !== 1'b1; k++) @(negedge mclk);
    if (done !== 1'b1) begin
      error_cnt++;
      $display("MISMATCH done exp 1 got %b", done);
      test_done();
    end
    go = 1'b0;
    @(negedge mclk);
  endtask : measure
  initial begin
    for (i = 0; i < 7; i++) begin
      tlt = rows[i].t;
      pwr_up(rows[i].m, rows[i].r);
      rate = rows[i].r ^ 2'h3; // a late strap change must not matter
      measure(rows[i].p);
      `CHK("high", rows[i].eh, th)
      `CHK("low", rows[i].el, tl)
      `CHK("series_res", rows[i].m == 2'h1, op.series_res)
    end
    // a 15 ns pull is ignored, then a 20 ns pull converts exactly once
    tlt = 16'h0005;
    pwr_up(2'h1, 2'h0);
    pc = 4'h3;
    go = 1'b1;
    repeat (60) @(negedge mclk);
    `CHK("short request", 1'b0, done)
    go = 1'b0;
    repeat (2) @(negedge mclk);
    measure(4'h4);
    `CHK("one-shot high", 8'h11, th)
    `CHK("one-shot low", 8'h0a, tl)
    lows = 0;
    repeat (80) begin
      @(negedge mclk);
      lows += int'(!line);
    end
    `CHK("extra cycles", 0, lows)
    pwr_up(2'h2, 2'h2);
    `CHK("chain high", 1'b1, line)
    rate = 2'h0;
    repeat (3) @(negedge mclk);
    `CHK("chain low", 1'b0, line)
    test_done();
  end
endmodule : tb_top
`default_nettype wire

// *** verilog/level_latch.sv ***
// Purpose: resolve a three-level strap once after power-up and hold it
// Assumes: rst stands for power-up; sense inputs are synchronous to mclk
// Notes:   the pin is ignored for good once the code is taken
`timescale 1ns/1ps
`default_nettype none
module level_latch (
  input  wire logic                     mclk,
  input  wire logic                     rst,
  input  wire pwm_temp_pkg::pin_sense_t sense,
  output var  pwm_temp_pkg::level_t     level,
  output var  logic                     valid
);

  // taken by a clocked process after release, never under reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      level <= pwm_temp_pkg::LEVEL_FLOAT;
      valid <= 1'b0;
    end else if (!valid) begin
      level <= pwm_temp_pkg::decode_level(sense);
      valid <= 1'b1;
    end
  end

  stable_code_a: assert property (@(posedge mclk) disable iff (rst) valid |=> valid && $stable(level))
    else $error("strap code changed after capture");

endmodule : level_latch
`default_nettype wire

// *** verilog/pwm_temp_out.sv ***
// Purpose: pwm temperature output: fixed high phase, temperature-coded low phase
// Assumes: temp_low_ticks is the modulator result at nominal rate, in time-base ticks
// Notes:   daisy-chain start-pulse handling is not built; chain mode only buffers the chain input
// Notes on behaviour
// - floating rate gives a nominal period near 99 ms at 25 C.
// - high phase length is fixed; only low phase follows temperature.
// - mode strap low one-shot, floating continuous, high daisy-chain.
// - continuous mode repeats cycles back to back without requests.
// - rate strap is taken once at power-up and later changes ignored.
// - one-shot mode emits exactly one cycle per request.
// - low pulses shorter than 20 ns are not taken as requests.
// - in one-shot the first rising edge follows the controller's release.
// - one-shot mode switches a series resistor into the pull-up.
// - rate strap low quarters both phases, float nominal, high doubles high, quarters low.
// - floating rate low phase tracks temperature, 53.6 to 104.5 ms.
// - low and high rate low phase tracks temperature, 13.4 to 26.1 ms.
// - in daisy-chain mode the rate pin is the chain input, not a rate.
`timescale 1ns/1ps
`default_nettype none
module pwm_temp_out #(
  parameter int        TICK_CYCLES  = pwm_temp_pkg::TICK_CYCLES,
  parameter int        TH_NOM_TICKS = pwm_temp_pkg::TH_NOM_TICKS,
  parameter bit        OPEN_DRAIN   = 1'b0
) (
  input  wire logic                          mclk,
  input  wire logic                          rst,
  input  wire pwm_temp_pkg::pin_sense_t      mode_select_pin,
  input  wire pwm_temp_pkg::pin_sense_t      rate_or_chain_input,
  input  wire logic [pwm_temp_pkg::PHASE_W-1:0] temp_low_ticks,
  input  wire logic                          out_in,
  output var  pwm_temp_pkg::pin_drive_t      out_pin
);

  localparam int PW = pwm_temp_pkg::PHASE_W;
  localparam int TW = pwm_temp_pkg::TICK_W;
  localparam int RW = pwm_temp_pkg::RUN_W;
  localparam int CW = PW + TW;

  if (TICK_CYCLES < 1 || TICK_CYCLES >= (1 << TW)) begin : bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (TH_NOM_TICKS < 4 || 2 * TH_NOM_TICKS >= (1 << PW)) begin : bad_th
    $error("TH_NOM_TICKS out of range");
  end
  // the low-run counter saturates, so the request threshold must not exceed its top value
  if (pwm_temp_pkg::REQ_LOW_CYC >= (1 << RW)) begin : bad_req
    $error("REQ_LOW_CYC does not fit the low-run counter");
  end

  pwm_temp_pkg::level_t mode;
  pwm_temp_pkg::level_t rate;
  logic                 mode_ok;
  logic                 rate_ok;

  level_latch u_mode (
    .mclk  (mclk),
    .rst   (rst),
    .sense (mode_select_pin),
    .level (mode),
    .valid (mode_ok)
  );
  level_latch u_rate (
    .mclk  (mclk),
    .rst   (rst),
    .sense (rate_or_chain_input),
    .level (rate),
    .valid (rate_ok)
  );

  pwm_temp_pkg::phase_t state_reg;
  pwm_temp_pkg::phase_t state_next;
  logic [TW-1:0]        tick_cnt_reg;
  logic [PW-1:0]        phase_cnt_reg;
  logic [PW-1:0]        len_reg;
  logic [RW-1:0]        low_run_reg;

  wire cfg_ok     = mode_ok && rate_ok;
  wire is_oneshot = mode == pwm_temp_pkg::LEVEL_LOW;
  wire is_cont    = mode == pwm_temp_pkg::LEVEL_FLOAT;
  wire is_chain   = mode == pwm_temp_pkg::LEVEL_HIGH;
  wire chain_in   = rate_or_chain_input.sense_high;

  // chain mode ignores the rate strap and runs nominal
  wire nominal    = is_chain || rate == pwm_temp_pkg::LEVEL_FLOAT;
  wire [PW-1:0] th_nom   = PW'(TH_NOM_TICKS);
  wire [PW-1:0] th_ticks = nominal ? th_nom :
                           (rate == pwm_temp_pkg::LEVEL_LOW) ? (th_nom >> 2) : (th_nom << 1);
  wire [PW-1:0] tl_raw   = nominal ? temp_low_ticks : (temp_low_ticks >> 2);
  // a zero length would wrap the phase counter, so clamp to one tick
  wire [PW-1:0] tl_ticks = (tl_raw == '0) ? PW'(1) : tl_raw;

  wire tick      = tick_cnt_reg == TW'(TICK_CYCLES - 1);
  wire phase_end = tick && (phase_cnt_reg == len_reg - PW'(1));
  wire long_low  = low_run_reg >= RW'(pwm_temp_pkg::REQ_LOW_CYC);
  wire start_req = is_oneshot && out_in && long_low;
  wire entering  = state_next != state_reg;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      pwm_temp_pkg::ST_IDLE: begin
        if (cfg_ok && (is_cont || start_req))
          state_next = pwm_temp_pkg::ST_HIGH;
      end
      pwm_temp_pkg::ST_HIGH: begin
        if (phase_end)
          state_next = pwm_temp_pkg::ST_LOW;
      end
      pwm_temp_pkg::ST_LOW: begin
        if (phase_end)
          state_next = is_cont ? pwm_temp_pkg::ST_HIGH : pwm_temp_pkg::ST_IDLE;
      end
      default: state_next = pwm_temp_pkg::ST_IDLE;
    endcase
  end

  wire level_next = (state_next == pwm_temp_pkg::ST_IDLE) ? (is_chain ? chain_in : 1'b1) :
                    (state_next == pwm_temp_pkg::ST_HIGH);
  // open drain only sinks; push-pull drives once the straps are known
  wire oe_next    = cfg_ok && (OPEN_DRAIN ? !level_next : 1'b1);
  wire res_next   = cfg_ok && is_oneshot;

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_reg <= pwm_temp_pkg::ST_IDLE;
      len_reg   <= PW'(1);
    end else begin
      state_reg <= state_next;
      if (entering)
        len_reg <= (state_next == pwm_temp_pkg::ST_HIGH) ? th_ticks : tl_ticks;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst || entering) begin
      tick_cnt_reg  <= '0;
      phase_cnt_reg <= '0;
    end else begin
      tick_cnt_reg  <= tick ? '0 : tick_cnt_reg + TW'(1);
      if (tick)
        phase_cnt_reg <= phase_cnt_reg + PW'(1);
    end
  end

  // counts consecutive low samples on the line while waiting for a request
  always_ff @(posedge mclk) begin
    if (rst || out_in || state_reg != pwm_temp_pkg::ST_IDLE)
      low_run_reg <= '0;
    else if (low_run_reg != '1)
      low_run_reg <= low_run_reg + RW'(1);
  end

  // cycle count of the current phase, read only by the length checks below
  logic [CW-1:0]        phase_cyc_reg;

  always_ff @(posedge mclk) begin
    if (rst || entering)
      phase_cyc_reg <= '0;
    else
      phase_cyc_reg <= phase_cyc_reg + CW'(1);
  end

  always_ff @(posedge mclk) begin
    if (rst)
      out_pin <= '0;
    else
      out_pin <= '{level: level_next, oe: oe_next, series_res: res_next};
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  phase_level_a: assert property (state_reg != pwm_temp_pkg::ST_IDLE |->
      out_pin.level == (state_reg == pwm_temp_pkg::ST_HIGH))
    else $error("output level does not match phase");
  high_length_a: assert property (state_reg == pwm_temp_pkg::ST_HIGH |-> len_reg == th_ticks)
    else $error("high phase length not fixed");
  cont_repeat_a: assert property (is_cont && state_reg == pwm_temp_pkg::ST_LOW && phase_end |=>
      state_reg == pwm_temp_pkg::ST_HIGH)
    else $error("continuous mode did not restart");
  oneshot_single_a: assert property (is_oneshot && state_reg == pwm_temp_pkg::ST_LOW && phase_end |=>
      state_reg == pwm_temp_pkg::ST_IDLE [*2])
    else $error("one-shot produced a second cycle");
  short_low_a: assert property (is_oneshot && state_reg == pwm_temp_pkg::ST_IDLE &&
      out_in && !long_low |=> state_reg == pwm_temp_pkg::ST_IDLE)
    else $error("short low pulse taken as request");
  release_start_a: assert property (cfg_ok && start_req && state_reg == pwm_temp_pkg::ST_IDLE |=>
      state_reg == pwm_temp_pkg::ST_HIGH ##0 out_pin.level)
    else $error("release did not start the cycle");
  series_res_a: assert property (cfg_ok |=> out_pin.series_res == is_oneshot)
    else $error("series resistor state wrong");
  low_scale_a: assert property (state_reg == pwm_temp_pkg::ST_HIGH && phase_end &&
      temp_low_ticks >= PW'(4) |=> len_reg == (nominal ? $past(temp_low_ticks) : $past(temp_low_ticks) >> 2))
    else $error("low phase scaling wrong");
  chain_rate_a: assert property (is_chain |-> th_ticks == th_nom)
    else $error("chain mode used rate strap");
  rate_hold_a: assert property (cfg_ok |=> $stable(rate) && $stable(mode))
    else $error("strap level changed after power-up");
  chain_idle_a: assert property (is_chain |-> state_reg == pwm_temp_pkg::ST_IDLE)
    else $error("chain mode started a conversion");
  chain_follow_a: assert property (cfg_ok && is_chain |=> out_pin.level == $past(chain_in))
    else $error("chain input not buffered to the output");
  oneshot_wait_a: assert property (is_oneshot && state_reg == pwm_temp_pkg::ST_IDLE && !start_req |=>
      state_reg == pwm_temp_pkg::ST_IDLE)
    else $error("one-shot converted without a request");
  req_width_a: assert property ((cfg_ok && is_oneshot && !out_in &&
      state_reg == pwm_temp_pkg::ST_IDLE) [*4] ##1 out_in |=> state_reg == pwm_temp_pkg::ST_HIGH)
    else $error("long low pulse not taken as request");
  cont_run_a: assert property (cfg_ok && is_cont |=> state_reg != pwm_temp_pkg::ST_IDLE)
    else $error("continuous mode went idle");
  idle_drive_a: assert property (cfg_ok && is_oneshot && !start_req &&
      state_reg == pwm_temp_pkg::ST_IDLE |=> out_pin.level)
    else $error("one-shot idle level not high");
  phase_bound_a: assert property (state_reg != pwm_temp_pkg::ST_IDLE |-> phase_cnt_reg < len_reg)
    else $error("phase counter ran past the phase length");
  tick_bound_a: assert property (tick_cnt_reg < TW'(TICK_CYCLES))
    else $error("time-base counter out of range");
  oe_mode_a: assert property (cfg_ok |=> out_pin.oe == (OPEN_DRAIN ? !out_pin.level : 1'b1))
    else $error("output enable does not match the output type");
  high_cycles_a: assert property (state_reg == pwm_temp_pkg::ST_HIGH && phase_end |->
      phase_cyc_reg == CW'(th_ticks * TICK_CYCLES - 1))
    else $error("high phase lasted the wrong number of cycles");
  low_cycles_a: assert property (state_reg == pwm_temp_pkg::ST_LOW && phase_end |->
      phase_cyc_reg == CW'(len_reg * TICK_CYCLES - 1))
    else $error("low phase lasted the wrong number of cycles");

  cont_cycle_c: cover property (is_cont && state_reg == pwm_temp_pkg::ST_LOW ##1 state_reg == pwm_temp_pkg::ST_HIGH);
  oneshot_req_c: cover property (is_oneshot && start_req && state_reg == pwm_temp_pkg::ST_IDLE);
  short_pulse_c: cover property (is_oneshot && out_in && low_run_reg != '0 && !long_low);
  chain_buf_c: cover property (is_chain && out_pin.level != $past(out_pin.level));
  low_rate_c: cover property (rate == pwm_temp_pkg::LEVEL_LOW && state_reg == pwm_temp_pkg::ST_LOW);

endmodule : pwm_temp_out
`default_nettype wire

// *** verilog/pwm_temp_pkg.sv ***
// Purpose: shared types, constants and pin decoding for the pwm temperature output
// Assumes: 200 MHz mclk; phases are timed in ticks of a fixed time base
// Notes:   three-level pins arrive as two comparator senses (high, low); float is neither
`default_nettype none
package pwm_temp_pkg;

  typedef enum logic [1:0] {LEVEL_LOW, LEVEL_FLOAT, LEVEL_HIGH} level_t;

  typedef enum logic [1:0] {ST_IDLE, ST_HIGH, ST_LOW} phase_t;

  typedef struct packed {
    logic sense_high;
    logic sense_low;
  } pin_sense_t;

  typedef struct packed {
    logic level;
    logic oe;
    logic series_res;
  } pin_drive_t;

  localparam int CLK_PERIOD_PS    = 5000;
  localparam int TICK_PS          = 10000000;
  localparam int TICK_CYCLES      = TICK_PS / CLK_PERIOD_PS;
  localparam int PERIOD_NOM_MS    = 99;
  localparam int TH_NOM_US        = 34000;
  // scaled in two steps so the intermediate product stays inside a 32-bit int
  localparam int TH_NOM_TICKS     = (TH_NOM_US * 1000) / (TICK_PS / 1000);
  localparam int REQ_LOW_PS       = 20000;
  localparam int REQ_LOW_CYC      = (REQ_LOW_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_W           = 12;
  localparam int PHASE_W          = 16;
  localparam int RUN_W            = 3;

  function automatic level_t decode_level(input pin_sense_t s);
    if (s.sense_high)
      return LEVEL_HIGH;
    else if (s.sense_low)
      return LEVEL_LOW;
    else
      return LEVEL_FLOAT;
  endfunction : decode_level

endpackage : pwm_temp_pkg
`default_nettype wire
